/* ext_irq_pkg.sv */
// constants and types for the external pin interrupt unit
`default_nettype none
package ext_irq_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] SENSE_OFS = 8'h00;
   localparam logic [7:0] EMASK_OFS = 8'h04;
   localparam logic [7:0] EFLAG_OFS = 8'h08;
   localparam logic [7:0] GENABLE_OFS = 8'h0C;
   localparam logic [7:0] GFLAG_OFS = 8'h10;
   localparam logic [7:0] CMASK0_OFS = 8'h14;
   localparam logic [7:0] CMASK1_OFS = 8'h18;
   localparam logic [7:0] CMASK2_OFS = 8'h1C;
   // field positions and widths
   localparam int PIN0_SENSE_LSB = 0;
   localparam int PIN1_SENSE_LSB = 2;
   localparam int SENSE_BITS = 4;
   localparam int EXT_PINS = 2;
   localparam int GROUPS = 3;
   localparam int CHANGE_INPUTS = 24;
   localparam int PIN0_SYNC_BIT = 24;
   localparam int PIN1_SYNC_BIT = 25;
   localparam int SYNC_BITS = 26;
   localparam int IRQ_BITS = 5;
   localparam int IRQ_GRP_LSB = 2;
   // group 1 has inputs 8 to 14 only; bit 15 is absent
   localparam logic [23:0] CMASK_IMPL = 24'hFF7FFF;
   // reset values
   localparam logic [3:0] SENSE_RST = 4'h0;
   localparam logic [1:0] EMASK_RST = 2'h0;
   localparam logic [2:0] GROUP_RST = 3'h0;
   localparam logic [23:0] CMASK_RST = 24'h000000;
   localparam logic [25:0] SYNC_RST = 26'h3FFFFFF;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
   // sense mode encoding of each pin's two control bits
   typedef enum logic [1:0] {
      SENSE_LOW = 2'h0,
      SENSE_ANY = 2'h1,
      SENSE_FALL = 2'h2,
      SENSE_RISE = 2'h3
   } sense_mode_t;
   // captured address phase of one bus transfer
   typedef struct packed {
      logic [7:0] ofs;
      logic wr;
      logic act;
   } bus_phase_t;
endpackage : ext_irq_pkg
`default_nettype wire

/* ext_pin_irq_unit.sv */
// external pin and pin-change interrupt unit with an AHB-Lite slave
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (R1) Pin activity raises interrupts even when the pin is driven as output.
// (R2) Group 2/1/0 request on toggle of unmasked inputs 16-23, 8-14, 0-7.
// (R3) Per-input mask bits select which inputs feed their group request.
// (R4) Pin-change detection works without the I/O clock running.
// (R5) Pin 1 sense from bits 3:2: low, any change, falling, rising.
// (R6) Pin 0 sense from bits 1:0 with the same encoding.
// (R7) Enabled low-level mode requests continuously while the pin is low.
// (R8) Edge detection on external pins only while the I/O clock runs.
// (R9) Low level on either pin detected without the I/O clock.
// (R10) Level vanishing during start-up wakes the part but gives no interrupt.
// (R11) Pins are sampled before edge detection; pulses over one clock count.
// (R12) Source must hold a level request until the current instruction ends.
// (R13) Pin interrupt needs both the global enable and its mask bit.
// (R14) Mask bit 1 enables pin 1, bit 0 pin 0; each has its own vector.
// (R15) Unused upper bits of sense and mask registers read as zero.
// (R16) Pin flag sets on detected edge; cleared by vector or writing one.
// (R17) Pin flag is held cleared while the pin is in low-level mode.
// (R18) Group flag sets on change; vectors only with group and global enable.
// (R19) Each pin passes a two-stage synchroniser before edge comparison.
module ext_pin_irq_unit (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire logic ext_pin_zero,
   input wire logic ext_pin_one,
   input wire logic [23:0] change_inputs,
   input wire logic core_global_enable,
   input wire logic io_clock_run,
   input wire logic [4:0] vector_ack,
   output logic [4:0] irq_request,
   output logic wake_request
);

   // edge or change seen between two samples in the given mode
   function automatic logic sense_hit(
      input logic [1:0] mode,
      input logic cur,
      input logic prev
   );
      logic hit;
      hit = 1'b0;
      case (mode)
         ext_irq_pkg::SENSE_ANY: hit = cur ^ prev;
         ext_irq_pkg::SENSE_FALL: hit = prev & ~cur;
         ext_irq_pkg::SENSE_RISE: hit = cur & ~prev;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : sense_hit

   // pin samples
   logic [25:0] sync1_ff;
   logic [25:0] sync2_ff;
   logic [25:0] prev_ff;
   // registers
   logic [3:0] sense_ff;
   logic [1:0] emask_ff;
   logic [1:0] eflag_ff;
   logic [2:0] genable_ff;
   logic [2:0] gflag_ff;
   logic [23:0] cmask_ff;
   // bus and outputs
   ext_irq_pkg::bus_phase_t phase_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic [4:0] irq_ff;
   logic wake_ff;

   // address phase capture
   wire take = hsel & hready & htrans[1];
   ext_irq_pkg::bus_phase_t nxt_phase;
   assign nxt_phase.ofs = haddr[7:0];
   assign nxt_phase.wr = hwrite;
   assign nxt_phase.act = take;
   wire [7:0] wofs = phase_ff.ofs;
   wire wr_now = phase_ff.act & phase_ff.wr;

   // write strobes in the data phase
   wire we_sense = wr_now & (wofs == ext_irq_pkg::SENSE_OFS);
   wire we_emask = wr_now & (wofs == ext_irq_pkg::EMASK_OFS);
   wire we_eflag = wr_now & (wofs == ext_irq_pkg::EFLAG_OFS);
   wire we_gen = wr_now & (wofs == ext_irq_pkg::GENABLE_OFS);
   wire we_gflag = wr_now & (wofs == ext_irq_pkg::GFLAG_OFS);
   wire we_cm0 = wr_now & (wofs == ext_irq_pkg::CMASK0_OFS);
   wire we_cm1 = wr_now & (wofs == ext_irq_pkg::CMASK1_OFS);
   wire we_cm2 = wr_now & (wofs == ext_irq_pkg::CMASK2_OFS);

   // read selection on the address phase offset
   wire [7:0] rofs = haddr[7:0];
   wire [31:0] rd_word =
      ({32{rofs == ext_irq_pkg::SENSE_OFS}} & {28'h0, sense_ff}) | // R15
      ({32{rofs == ext_irq_pkg::EMASK_OFS}} & {30'h0, emask_ff}) | // R15
      ({32{rofs == ext_irq_pkg::EFLAG_OFS}} & {30'h0, eflag_ff}) |
      ({32{rofs == ext_irq_pkg::GENABLE_OFS}} & {29'h0, genable_ff}) |
      ({32{rofs == ext_irq_pkg::GFLAG_OFS}} & {29'h0, gflag_ff}) |
      ({32{rofs == ext_irq_pkg::CMASK0_OFS}} & {24'h0, cmask_ff[7:0]}) |
      ({32{rofs == ext_irq_pkg::CMASK1_OFS}} & {24'h0, cmask_ff[15:8]}) |
      ({32{rofs == ext_irq_pkg::CMASK2_OFS}} & {24'h0, cmask_ff[23:16]});

   // raw pins, read whatever drives them
   wire [25:0] pins_raw = {ext_pin_one, ext_pin_zero, change_inputs}; // R1

   // synchronised pin levels and their previous samples
   wire pin0_cur = sync2_ff[ext_irq_pkg::PIN0_SYNC_BIT];
   wire pin1_cur = sync2_ff[ext_irq_pkg::PIN1_SYNC_BIT];
   wire pin0_prev = prev_ff[ext_irq_pkg::PIN0_SYNC_BIT];
   wire pin1_prev = prev_ff[ext_irq_pkg::PIN1_SYNC_BIT];
   wire [1:0] mode0 = sense_ff[ext_irq_pkg::PIN0_SENSE_LSB +: 2]; // R6
   wire [1:0] mode1 = sense_ff[ext_irq_pkg::PIN1_SENSE_LSB +: 2]; // R5

   // level mode and low level per pin, no I/O clock needed
   wire [1:0] lvl_mode = {mode1 == ext_irq_pkg::SENSE_LOW,
                          mode0 == ext_irq_pkg::SENSE_LOW};
   wire [1:0] lvl_low = lvl_mode & ~{pin1_cur, pin0_cur}; // R9

   // edge hits only while the I/O clock runs
   wire [1:0] ext_hit = {2{io_clock_run}} & // R8
      {sense_hit(mode1, pin1_cur, pin1_prev),
       sense_hit(mode0, pin0_cur, pin0_prev)}; // R11

   // pin-change toggles, masked per input, no I/O clock gating
   wire [23:0] chg = (sync2_ff[23:0] ^ prev_ff[23:0]) & cmask_ff; // R3 R4
   wire [2:0] grp_hit = {|chg[23:16], |chg[15:8], |chg[7:0]}; // R2

   // flag clears from software ones and vector entry
   wire [1:0] eclr = ({2{we_eflag}} & hwdata[1:0]) |
                     vector_ack[1:0];
   wire [2:0] gclr = ({3{we_gflag}} & hwdata[2:0]) |
                     vector_ack[4:2];

   // flags: a new hit wins over a clear in the same cycle
   wire [1:0] nxt_eflag = ~lvl_mode & // R17
                          ((eflag_ff & ~eclr) | ext_hit); // R16
   wire [2:0] nxt_gflag = (gflag_ff & ~gclr) | grp_hit; // R18

   // per-vector requests gated by mask and global enable
   wire [1:0] ext_src = (lvl_mode & lvl_low) | // R7
                        (~lvl_mode & eflag_ff);
   wire [1:0] nxt_ext_irq = ext_src & emask_ff & // R14
                            {2{core_global_enable}}; // R13
   wire [2:0] nxt_grp_irq = gflag_ff & genable_ff &
                            {3{core_global_enable}}; // R18
   wire [4:0] nxt_irq = {nxt_grp_irq, nxt_ext_irq};

   // wake on enabled low level or enabled group change
   wire nxt_wake = |(lvl_low & emask_ff) | // R9 R10
                   |(grp_hit & genable_ff); // R4

   // two-stage synchroniser, then one more sample for comparison
   // change inputs may toggle falsely after reset; masks are clear then
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= ext_irq_pkg::SYNC_RST;
         sync2_ff <= ext_irq_pkg::SYNC_RST;
         prev_ff <= ext_irq_pkg::SYNC_RST;
      end else begin
         sync1_ff <= pins_raw; // R19
         sync2_ff <= sync1_ff; // R19
         prev_ff <= sync2_ff; // R11
      end
   end

   // bus phase, read data and ready
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_ff <= '0;
         hrdata_ff <= 32'h0;
         hreadyout_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         hrdata_ff <= (take & ~hwrite) ? rd_word : 32'h0;
         hreadyout_ff <= 1'b1;
      end
   end

   // control registers written by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sense_ff <= ext_irq_pkg::SENSE_RST;
         emask_ff <= ext_irq_pkg::EMASK_RST;
         genable_ff <= ext_irq_pkg::GROUP_RST;
         cmask_ff <= ext_irq_pkg::CMASK_RST;
      end else begin
         if (we_sense) sense_ff <= hwdata[3:0];
         if (we_emask) emask_ff <= hwdata[1:0];
         if (we_gen) genable_ff <= hwdata[2:0];
         if (we_cm0) cmask_ff[7:0] <= hwdata[7:0];
         if (we_cm1) cmask_ff[15:8] <= hwdata[7:0] &
            ext_irq_pkg::CMASK_IMPL[15:8];
         if (we_cm2) cmask_ff[23:16] <= hwdata[7:0];
      end
   end

   // flags and outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eflag_ff <= ext_irq_pkg::EMASK_RST;
         gflag_ff <= ext_irq_pkg::GROUP_RST;
         irq_ff <= 5'h00;
         wake_ff <= 1'b0;
      end else begin
         eflag_ff <= nxt_eflag;
         gflag_ff <= nxt_gflag;
         irq_ff <= nxt_irq;
         wake_ff <= nxt_wake;
      end
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = ext_irq_pkg::HRESP_OKAY;
   assign irq_request = irq_ff;
   assign wake_request = wake_ff;

   // checks on the detection and gating paths
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   level_request_a: assert property ( // R7
      (mode0 == ext_irq_pkg::SENSE_LOW && emask_ff[0] &&
       core_global_enable && !pin0_cur) |=> irq_ff[0])
      else $error("low level on pin 0 gave no request");

   level_flag_clear_a: assert property ( // R17
      (mode1 == ext_irq_pkg::SENSE_LOW) |=> !eflag_ff[1])
      else $error("pin 1 flag set in level mode");

   falling_edge_flag_a: assert property ( // R6
      (io_clock_run && mode0 == ext_irq_pkg::SENSE_FALL &&
       pin0_prev && !pin0_cur) |=> eflag_ff[0])
      else $error("falling edge on pin 0 not flagged");

   rising_edge_flag_a: assert property ( // R5
      (io_clock_run && mode1 == ext_irq_pkg::SENSE_RISE &&
       !pin1_prev && pin1_cur) |=> eflag_ff[1])
      else $error("rising edge on pin 1 not flagged");

   no_clock_edge_a: assert property ( // R8
      (!io_clock_run && !eflag_ff[1]) |=> !eflag_ff[1])
      else $error("edge flag set without I/O clock");

   pin_to_flag_a: assert property ( // R19
      (io_clock_run && mode0 == ext_irq_pkg::SENSE_ANY &&
       $changed(sync2_ff[24]) && $stable(io_clock_run) &&
       $past(mode0) == ext_irq_pkg::SENSE_ANY) |=> eflag_ff[0])
      else $error("pin 0 change not flagged");

   group_change_a: assert property ( // R2
      (|chg[23:16]) |=> gflag_ff[2])
      else $error("group 2 change not flagged");

   masked_quiet_a: assert property ( // R3
      (gflag_ff == 3'h0 && chg == 24'h0) |=> gflag_ff == 3'h0)
      else $error("group flag set with no unmasked change");

   global_gate_a: assert property ( // R13
      irq_ff[1] |-> $past(core_global_enable) && $past(emask_ff[1]))
      else $error("pin 1 request without both enables");

   group_gate_a: assert property ( // R18
      irq_ff[4] |-> $past(genable_ff[2]) && $past(core_global_enable))
      else $error("group 2 request without both enables");

   reserved_zero_a: assert property ( // R15
      (take && !hwrite && rofs == ext_irq_pkg::EMASK_OFS)
      |=> hrdata_ff[31:2] == 30'h0)
      else $error("mask register upper bits not zero");

   // further checks on flags, wake and read-back
   sense_upper_zero_a: assert property ( // R15
      (take && !hwrite && rofs == ext_irq_pkg::SENSE_OFS)
      |=> hrdata_ff[31:4] == 28'h0)
      else $error("sense register upper bits not zero");

   unused_input_a: assert property ( // R2
      !cmask_ff[15])
      else $error("mask bit of absent input 15 set");

   pin0_level_clear_a: assert property ( // R17
      (mode0 == ext_irq_pkg::SENSE_LOW) |=> !eflag_ff[0])
      else $error("pin 0 flag set in level mode");

   hit_over_clear_a: assert property ( // R16
      (ext_hit[0] && !lvl_mode[0]) |=> eflag_ff[0])
      else $error("pin 0 edge lost against a clear");

   soft_clear_a: assert property ( // R16
      (we_eflag && hwdata[0] && !ext_hit[0]) |=> !eflag_ff[0])
      else $error("pin 0 flag survived a write of one");

   vector_clear_a: assert property ( // R18
      (vector_ack[2] && !grp_hit[0]) |=> !gflag_ff[0])
      else $error("group 0 flag survived vector entry");

   group0_change_a: assert property ( // R2
      (|chg[7:0]) |=> gflag_ff[0])
      else $error("group 0 change not flagged");

   group1_change_a: assert property ( // R2
      (|chg[15:8]) |=> gflag_ff[1])
      else $error("group 1 change not flagged");

   pin0_gate_a: assert property ( // R13
      irq_ff[0] |-> $past(core_global_enable) && $past(emask_ff[0]))
      else $error("pin 0 request without both enables");

   wake_level_a: assert property ( // R9
      (lvl_low[1] && emask_ff[1]) |=> wake_ff)
      else $error("enabled low level on pin 1 gave no wake");

   wake_quiet_a: assert property ( // R4
      (!(|(lvl_low & emask_ff)) && !(|(grp_hit & genable_ff)))
      |=> !wake_ff)
      else $error("wake raised with no enabled source");

   cover_level_wake_c: cover property (lvl_low[0] && emask_ff[0]
      ##1 wake_ff);
   cover_edge_irq_c: cover property (ext_hit[1] ##1 eflag_ff[1]
      ##1 irq_ff[1]);
   cover_group_clear_c: cover property (gflag_ff[0] && gclr[0]
      ##1 !gflag_ff[0]);
   // level request held, and a flag cleared by vector entry
   cover_level_hold_c: cover property (irq_ff[1] && lvl_mode[1]
      ##1 irq_ff[1]);
   cover_vector_entry_c: cover property (vector_ack[2]
      ##1 !gflag_ff[0]);

endmodule : ext_pin_irq_unit
`default_nettype wire

/* core_irq_model.sv */
// model of the core's interrupt entry answering pending requests
`timescale 1ns/10ps
`default_nettype none
module core_irq_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic serve,
   input wire logic core_global_enable,
   input wire logic [4:0] irq_request,
   output logic [4:0] vector_ack
);
   logic [4:0] pick;
   // lowest pending request is entered first
   assign pick = irq_request & ~(irq_request - 5'h01);
   // one-cycle entry pulse, none while the global flag is off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vector_ack <= 5'h00;
      end else begin
         vector_ack <= (serve && core_global_enable && vector_ack == 5'h00)
                       ? pick : 5'h00;
      end
   end
endmodule : core_irq_model
`default_nettype wire

/* test_external_pin_interrupt_unit.sv */
// self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
`default_nettype none
module test_external_pin_interrupt_unit;
   logic hclk, hresetn, hsel, hwrite, hreadyout, wake, gie, io_run, serve;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, hresp, pins;
   logic [23:0] chg;
   logic [4:0] ack, irq;
   int n_errors = 0;
   int compares = 0;
   ext_pin_irq_unit u_ext_pin_irq_unit (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_pin_zero(pins[0]),
      .ext_pin_one(pins[1]), .change_inputs(chg), .core_global_enable(gie),
      .io_clock_run(io_run), .vector_ack(ack), .irq_request(irq),
      .wake_request(wake));
   core_irq_model u_core_irq_model (.hclk(hclk), .hresetn(hresetn),
      .serve(serve), .core_global_enable(gie), .irq_request(irq),
      .vector_ack(ack));
   // free-running bus clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task automatic complete_run;
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick
   // bounded wait for hready sampled high
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         complete_run();
      end
   endtask : wait_rdy
   // one single word transfer, read data left in rd
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   task automatic pin(input int p, input logic v);
      pins[p] <= v;
      tick(6);
   endtask : pin
   // reset values, writable bits, unmapped offset 0x20
   task automatic sc_regs;
      logic [31:0] full [0:8];
      full = '{32'hF, 32'h3, 32'h0, 32'h7, 32'h0, 32'hFF, 32'h7F, 32'hFF,
               32'h0};
      for (int i = 0; i < 9; i++) begin
         rchk(8'(i * 4), 32'h0);
         bus(1'b1, 8'(i * 4), 32'hFFFFFFFF);
         rchk(8'(i * 4), full[i]);
         bus(1'b1, 8'(i * 4), 32'h0);
      end
      chk(32'(hresp), 32'h0);
   endtask : sc_regs
   // change, falling and rising modes on both pins
   task automatic sc_edges;
      logic [31:0] b;
      gie <= 1'b1;
      bus(1'b1, ext_irq_pkg::EMASK_OFS, 32'h3);
      for (int p = 0; p < 2; p++) begin
         for (int m = 1; m < 4; m++) begin
            b = 32'(1 << p);
            bus(1'b1, ext_irq_pkg::SENSE_OFS, 32'(m << (2 * p)));
            pin(p, 1'b0);
            rchk(ext_irq_pkg::EFLAG_OFS, (m != 3) ? b : 32'h0);
            chk(32'(irq), (m != 3) ? b : 32'h0);
            bus(1'b1, ext_irq_pkg::EFLAG_OFS, 32'h3);
            pin(p, 1'b1);
            rchk(ext_irq_pkg::EFLAG_OFS, (m != 2) ? b : 32'h0);
            bus(1'b1, ext_irq_pkg::EFLAG_OFS, 32'h3);
         end
      end
      gie <= 1'b0;
      bus(1'b1, ext_irq_pkg::SENSE_OFS, 32'h2);
      pin(0, 1'b0);
      chk(32'(irq), 32'h0);
      rchk(ext_irq_pkg::EFLAG_OFS, 32'h1);
      pin(0, 1'b1);
      bus(1'b1, ext_irq_pkg::EFLAG_OFS, 32'h3);
      io_run <= 1'b0;
      pin(0, 1'b0);
      rchk(ext_irq_pkg::EFLAG_OFS, 32'h0);
      io_run <= 1'b1;
      pin(0, 1'b1);
   endtask : sc_edges
   // low level requests steadily with the I/O clock stopped
   task automatic sc_level;
      gie <= 1'b1;
      io_run <= 1'b0;
      bus(1'b1, ext_irq_pkg::SENSE_OFS, 32'h0);
      bus(1'b1, ext_irq_pkg::EFLAG_OFS, 32'h3);
      pin(1, 1'b0);
      chk(32'(irq), 32'h2);
      chk(32'(wake), 32'h1);
      tick(40);
      chk(32'(irq), 32'h2);
      rchk(ext_irq_pkg::EFLAG_OFS, 32'h0);
      pin(1, 1'b1);
      chk(32'(irq), 32'h0);
      io_run <= 1'b1;
   endtask : sc_level
   // group masks, unused input 15, clear by vector entry
   task automatic sc_groups;
      int bits [0:5];
      logic [31:0] exp [0:5];
      bits = '{1, 0, 15, 8, 23, 16};
      exp = '{32'h0, 32'h1, 32'h0, 32'h2, 32'h4, 32'h0};
      bus(1'b1, ext_irq_pkg::GENABLE_OFS, 32'h7);
      io_run <= 1'b0;
      bus(1'b1, ext_irq_pkg::CMASK0_OFS, 32'h01);
      bus(1'b1, ext_irq_pkg::CMASK1_OFS, 32'hFF);
      bus(1'b1, ext_irq_pkg::CMASK2_OFS, 32'h80);
      for (int i = 0; i < 6; i++) begin
         chg[bits[i]] <= ~chg[bits[i]];
         tick(6);
         rchk(ext_irq_pkg::GFLAG_OFS, exp[i]);
         chk(32'(irq), exp[i] << 2);
         bus(1'b1, ext_irq_pkg::GFLAG_OFS, 32'h7);
      end
      serve <= 1'b1;
      chg[0] <= 1'b0;
      tick(10);
      rchk(ext_irq_pkg::GFLAG_OFS, 32'h0);
      serve <= 1'b0;
   endtask : sc_groups
   // reset, then the scenarios in turn
   initial begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pins = 2'h3;
      chg = 24'h000000;
      gie = 1'b0;
      io_run = 1'b1;
      serve = 1'b0;
      tick(8);
      hresetn <= 1'b1;
      tick(1);
      sc_regs();
      sc_edges();
      sc_level();
      sc_groups();
      complete_run();
   end
endmodule : test_external_pin_interrupt_unit
`default_nettype wire
